// [hdl/sps_pkg.sv]
// Constants shared by the servo poll status word logic.
// Assumes a single 250 MHz controller clock and an active-high async reset.
`default_nettype none

package sps_pkg;

  // ==========================================================================
  // Word layout
  localparam int FLAG_WIDTH = 16;

  localparam int BIT_IMM_CMD_DONE     = 15;
  localparam int BIT_NV_CHECKSUM      = 14;
  localparam int BIT_PROGRAM_DONE     = 13;
  localparam int BIT_CMD_FAULT        = 12;
  localparam int BIT_STOP_EXIT        = 11;
  localparam int BIT_SUPPLY_FAULT     = 10;
  localparam int BIT_HOLD_ERROR       = 9;
  localparam int BIT_MOVE_ERROR       = 8;
  localparam int BIT_RX_OVERFLOW      = 7;
  localparam int BIT_ARMED_HIT        = 6;
  localparam int BIT_RX_TOO_LONG      = 5;
  localparam int BIT_RX_FRAMING       = 4;
  localparam int BIT_SHUTDOWN         = 3;
  localparam int BIT_SOFT_LIMIT       = 2;
  localparam int BIT_RX_CHECKSUM      = 1;
  localparam int BIT_RX_ABORTED       = 0;

  // ==========================================================================
  // Values after reset and special masks
  localparam logic [FLAG_WIDTH-1:0] FLAGS_RESET    = 16'h0000;
  localparam logic [FLAG_WIDTH-1:0] CLEAR_ALL_MASK = 16'hFFFF;
  localparam logic                  REPLY_RESET    = 1'h0;

  // ==========================================================================
  // Serial receive limits
  localparam int RX_BUFFER_BYTES = 31;
  localparam int RX_COUNT_WIDTH  = 6;

  // ==========================================================================
  // Serial protocol modes
  typedef enum logic [1:0] {
    SPS_PROTO_ASCII   = 2'b00,
    SPS_PROTO_BINARY8 = 2'b01,
    SPS_PROTO_BINARY9 = 2'b10,
    SPS_PROTO_MODBUS  = 2'b11
  } sps_proto_type;

endpackage

`default_nettype wire

// [hdl/sps_flag_cell.sv]
// One double-buffered latched flag of the poll status word.
// Assumes set, poll and clear come from logic on the same clock.
`default_nettype none

module sps_flag_cell
  import sps_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic set_event,
  input  wire logic poll,
  input  wire logic clear,
  output var  logic pending,
  output var  logic reported
);

  // ==========================================================================
  // Next values
  logic next_pending;
  logic next_reported;

  // Event lands in pending, so a clear in the same cycle cannot drop it
  assign next_pending  = set_event | (pending & ~poll);
  // Clear reaches only what a poll has already shown
  assign next_reported = (reported & ~clear) | (pending & poll);

  // ==========================================================================
  // State
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pending  <= 1'b0;
      reported <= 1'b0;
    end else begin
      pending  <= next_pending;
      reported <= next_reported;
    end
  end

endmodule

`default_nettype wire

// [hdl/sps_poll_status.sv]
// Servo poll status word: sixteen latched condition flags, poll and clear commands.
// Assumes all condition inputs and commands come from logic on the clk domain.
//
// Overview of operation
// - Word is sixteen bits, one condition each
// - Bit 15 sets on immediate command done
// - Bit 14 sets on memory checksum fault
// - Bit 13 sets when program buffer finishes
// - Bit 12 sets on command execution fault
// - Bit 11 sets on stop-condition motion exit
// - Bit 10 sets on under or overvoltage
// - Bit 9 sets on holding error limit
// - Bit 8 sets on moving error limit
// - Bit 7 sets on receive buffer overflow
// - Bit 6 sets on armed check condition
// - Bit 5 sets on packet over 31 bytes
// - Bit 4 sets on byte framing fault
// - Bit 3 sets on kill; clear always works
// - Bit 2 sets on soft stop limit
// - Bit 1 checksum fault, nine-bit and Modbus only
// - Bit 0 sets on data error or restart
// - Host may poll at any time
// - Only poll and clear commands exist
// - Bits latch until cleared by command
// - Poll replies ack if zero, else word
// - Clear mask clears chosen bits only
// - Double buffered: clear only reported bits
`default_nettype none

module sps_poll_status
  import sps_pkg::*;
#(
  parameter int COUNT_WIDTH = RX_COUNT_WIDTH
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Host commands
  input  wire logic                  status_query_cmd,
  input  wire logic                  status_clear_cmd,
  input  wire logic [FLAG_WIDTH-1:0] clear_mask,
  // Condition sources
  input  wire logic                  imm_cmd_done,
  input  wire logic                  nonvolatile_checksum_fault,
  input  wire logic                  program_cmds_done,
  input  wire logic                  cmd_exec_fault,
  input  wire logic                  stop_condition_exit,
  input  wire logic                  supply_undervolt,
  input  wire logic                  supply_overvolt,
  input  wire logic                  pos_err_over_hold,
  input  wire logic                  holding_state,
  input  wire logic                  pos_err_over_move,
  input  wire logic                  moving_state,
  input  wire logic                  rx_fifo_overflow,
  input  wire logic                  armed_condition_hit,
  input  wire logic                  internal_check_active,
  input  wire logic                  rx_byte_stb,
  input  wire logic [COUNT_WIDTH-1:0] rx_byte_count,
  input  wire logic                  rx_framing_fault,
  input  wire logic                  shutdown_condition_active,
  input  wire logic                  soft_limit_reached,
  input  wire logic                  rx_checksum_fault,
  input  wire logic [1:0]            protocol_mode,
  input  wire logic                  rx_data_fault,
  input  wire logic                  rx_packet_restart,
  // Host replies
  output var  logic                  reply_valid,
  output var  logic                  reply_ack,
  output var  logic [FLAG_WIDTH-1:0] reply_word,
  output logic      [FLAG_WIDTH-1:0] poll_condition_flags
);

  // ==========================================================================
  // Condition qualification
  sps_proto_type proto;
  logic          checksum_mode;
  logic          packet_too_long;
  logic          shutdown_prev;
  logic          shutdown_rise;
  logic          hold_violation;
  logic          move_violation;
  logic          supply_fault;
  logic          armed_hit_in_check;
  logic          packet_aborted;

  assign proto         = sps_proto_type'(protocol_mode);
  // Checksum exists only in the nine-bit binary and Modbus framings
  assign checksum_mode = (proto == SPS_PROTO_BINARY9) || (proto == SPS_PROTO_MODBUS);

  // Count includes the byte now strobed, so one past the buffer is too long
  assign packet_too_long = rx_byte_stb &&
                           (rx_byte_count > COUNT_WIDTH'(RX_BUFFER_BYTES));

  // Edge only: a persisting kill condition must not re-arm after a clear
  assign shutdown_rise = shutdown_condition_active & ~shutdown_prev;

  assign hold_violation     = pos_err_over_hold & holding_state;
  assign move_violation     = pos_err_over_move & moving_state;
  assign supply_fault       = supply_undervolt | supply_overvolt;
  assign armed_hit_in_check = armed_condition_hit & internal_check_active;
  assign packet_aborted     = rx_data_fault | rx_packet_restart;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shutdown_prev <= 1'b0;
    end else begin
      shutdown_prev <= shutdown_condition_active;
    end
  end

  // ==========================================================================
  // Event vector, one source per bit except bits 10 and 0, which OR two each
  logic [FLAG_WIDTH-1:0] event_vec;

  assign event_vec[BIT_IMM_CMD_DONE] = imm_cmd_done;
  assign event_vec[BIT_NV_CHECKSUM]  = nonvolatile_checksum_fault;
  assign event_vec[BIT_PROGRAM_DONE] = program_cmds_done;
  assign event_vec[BIT_CMD_FAULT]    = cmd_exec_fault;
  assign event_vec[BIT_STOP_EXIT]    = stop_condition_exit;
  assign event_vec[BIT_SUPPLY_FAULT] = supply_fault;
  assign event_vec[BIT_HOLD_ERROR]   = hold_violation;
  assign event_vec[BIT_MOVE_ERROR]   = move_violation;
  assign event_vec[BIT_RX_OVERFLOW]  = rx_fifo_overflow;
  assign event_vec[BIT_ARMED_HIT]    = armed_hit_in_check;
  assign event_vec[BIT_RX_TOO_LONG]  = packet_too_long;
  assign event_vec[BIT_RX_FRAMING]   = rx_framing_fault;
  assign event_vec[BIT_SHUTDOWN]     = shutdown_rise;
  assign event_vec[BIT_SOFT_LIMIT]   = soft_limit_reached;
  assign event_vec[BIT_RX_CHECKSUM]  = rx_checksum_fault & checksum_mode;
  assign event_vec[BIT_RX_ABORTED]   = packet_aborted;

  // ==========================================================================
  // Command decode
  logic                  poll;
  logic                  clear;
  logic [FLAG_WIDTH-1:0] clear_vec;

  // Poll accepted every cycle, motion or not
  assign poll      = status_query_cmd;
  assign clear     = status_clear_cmd;
  // A full mask of ones clears every reported bit
  assign clear_vec = clear_mask & {FLAG_WIDTH{clear}};

  // ==========================================================================
  // Flag storage
  logic [FLAG_WIDTH-1:0] pending;
  logic [FLAG_WIDTH-1:0] reported;
  logic [FLAG_WIDTH-1:0] word_now;

  genvar gi;
  generate
    for (gi = 0; gi < FLAG_WIDTH; gi++) begin : g_flag
      // Sixteen independent latches make up the word
      sps_flag_cell u_cell (
        .clk       (clk),
        .reset     (reset),
        .set_event (event_vec[gi]),
        .poll      (poll),
        .clear     (clear_vec[gi]),
        .pending   (pending[gi]),
        .reported  (reported[gi])
      );
    end
  endgenerate

  assign word_now             = pending | reported;
  assign poll_condition_flags = word_now;

  // ==========================================================================
  // Poll reply
  logic                  next_reply_ack;
  logic [FLAG_WIDTH-1:0] next_reply_word;

  // All-zero word answers with a bare acknowledge
  assign next_reply_ack  = (word_now == FLAGS_RESET);
  assign next_reply_word = poll ? word_now : reply_word;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reply_valid <= REPLY_RESET;
      reply_ack   <= REPLY_RESET;
      reply_word  <= FLAGS_RESET;
    end else begin
      reply_valid <= poll;
      reply_ack   <= poll ? next_reply_ack : reply_ack;
      reply_word  <= next_reply_word;
    end
  end

  // ==========================================================================
  // Checks

  set_latch_a : assert property (
    @(posedge clk) disable iff (reset)
    (event_vec != FLAGS_RESET) |=>
      ((word_now & $past(event_vec)) == $past(event_vec))
  ) else $error("event did not latch into the word");

  latch_keep_a : assert property (
    @(posedge clk) disable iff (reset)
    (!poll && !clear) |=> ((word_now & $past(word_now)) == $past(word_now))
  ) else $error("flag fell without a clear");

  set_wins_a : assert property (
    @(posedge clk) disable iff (reset)
    (clear && ((event_vec & clear_mask) != FLAGS_RESET)) |=>
      ((word_now & $past(event_vec)) == $past(event_vec))
  ) else $error("clear beat a simultaneous set");

  unread_keep_a : assert property (
    @(posedge clk) disable iff (reset)
    (clear && !poll) |=> ((pending & $past(pending)) == $past(pending))
  ) else $error("clear removed an unreported flag");

  mask_clear_a : assert property (
    @(posedge clk) disable iff (reset)
    (clear && !poll) |=>
      ((reported & $past(clear_mask)) == FLAGS_RESET) &&
      ((reported & ~$past(clear_mask)) == ($past(reported) & ~$past(clear_mask)))
  ) else $error("clear mask not applied exactly");

  reply_word_a : assert property (
    @(posedge clk) disable iff (reset)
    poll |=> reply_valid && (reply_word == $past(word_now)) &&
             (reply_ack == ($past(word_now) == FLAGS_RESET))
  ) else $error("poll reply wrong or late");

  reply_pulse_a : assert property (
    @(posedge clk) disable iff (reset)
    (!poll ##1 !poll) |-> !reply_valid
  ) else $error("reply without a poll");

  hold_gate_a : assert property (
    @(posedge clk) disable iff (reset)
    (pos_err_over_hold && !holding_state && !poll && !clear &&
     !word_now[BIT_HOLD_ERROR]) |=> !word_now[BIT_HOLD_ERROR]
  ) else $error("holding error set outside holding state");

  kill_edge_a : assert property (
    @(posedge clk) disable iff (reset)
    (shutdown_condition_active && $past(shutdown_condition_active) &&
     clear && clear_mask[BIT_SHUTDOWN] && !poll && !pending[BIT_SHUTDOWN]) |=>
      !word_now[BIT_SHUTDOWN]
  ) else $error("persisting kill condition re-set its flag");

  long_packet_a : assert property (
    @(posedge clk) disable iff (reset)
    (rx_byte_stb && (rx_byte_count > COUNT_WIDTH'(RX_BUFFER_BYTES))) |=>
      word_now[BIT_RX_TOO_LONG]
  ) else $error("overlong packet not flagged");

  checksum_mode_a : assert property (
    @(posedge clk) disable iff (reset)
    (!checksum_mode && !poll && !clear && !word_now[BIT_RX_CHECKSUM]) |=>
      !word_now[BIT_RX_CHECKSUM]
  ) else $error("checksum flag set in a mode without checksum");

  // ==========================================================================
  // Per-source set, gating, reply, poll and clear checks

  imm_done_set_a : assert property (
    @(posedge clk) disable iff (reset)
    imm_cmd_done |=> word_now[BIT_IMM_CMD_DONE]
  ) else $error("immediate command done not flagged");

  framing_set_a : assert property (
    @(posedge clk) disable iff (reset)
    rx_framing_fault |=> word_now[BIT_RX_FRAMING]
  ) else $error("framing fault not flagged");

  checksum_set_a : assert property (
    @(posedge clk) disable iff (reset)
    (rx_checksum_fault && protocol_mode[1]) |=> word_now[BIT_RX_CHECKSUM]
  ) else $error("checksum fault in checksum mode not flagged");

  supply_set_a : assert property (
    @(posedge clk) disable iff (reset)
    (supply_undervolt || supply_overvolt) |=> word_now[BIT_SUPPLY_FAULT]
  ) else $error("supply fault not flagged");

  hold_set_a : assert property (
    @(posedge clk) disable iff (reset)
    (pos_err_over_hold && holding_state) |=> word_now[BIT_HOLD_ERROR]
  ) else $error("holding error not flagged");

  move_set_a : assert property (
    @(posedge clk) disable iff (reset)
    (pos_err_over_move && moving_state) |=> word_now[BIT_MOVE_ERROR]
  ) else $error("moving error not flagged");

  abort_set_a : assert property (
    @(posedge clk) disable iff (reset)
    (rx_data_fault || rx_packet_restart) |=> word_now[BIT_RX_ABORTED]
  ) else $error("aborted packet not flagged");

  kill_set_a : assert property (
    @(posedge clk) disable iff (reset)
    (shutdown_condition_active && !$past(shutdown_condition_active)) |=>
      word_now[BIT_SHUTDOWN]
  ) else $error("kill condition onset not flagged");

  move_gate_a : assert property (
    @(posedge clk) disable iff (reset)
    (pos_err_over_move && !moving_state && !poll && !clear &&
     !word_now[BIT_MOVE_ERROR]) |=> !word_now[BIT_MOVE_ERROR]
  ) else $error("moving error set outside moving state");

  armed_gate_a : assert property (
    @(posedge clk) disable iff (reset)
    (armed_condition_hit && !internal_check_active && !poll && !clear &&
     !word_now[BIT_ARMED_HIT]) |=> !word_now[BIT_ARMED_HIT]
  ) else $error("armed condition flagged outside a check");

  short_packet_a : assert property (
    @(posedge clk) disable iff (reset)
    ((!rx_byte_stb || (rx_byte_count <= COUNT_WIDTH'(RX_BUFFER_BYTES))) && !poll && !clear &&
     !word_now[BIT_RX_TOO_LONG]) |=> !word_now[BIT_RX_TOO_LONG]
  ) else $error("packet within buffer size flagged too long");

  reply_stand_a : assert property (
    @(posedge clk) disable iff (reset)
    !poll |=> (reply_word == $past(reply_word)) && (reply_ack == $past(reply_ack))
  ) else $error("reply changed without a poll");

  poll_drain_a : assert property (
    @(posedge clk) disable iff (reset)
    poll |=> (pending == $past(event_vec))
  ) else $error("poll left stale unreported flags");

  poll_report_a : assert property (
    @(posedge clk) disable iff (reset)
    poll |=> ((reported & $past(pending)) == $past(pending))
  ) else $error("polled flag not moved to reported");

  unmasked_keep_a : assert property (
    @(posedge clk) disable iff (reset)
    clear |=>
      ((word_now & ~$past(clear_mask)) & $past(word_now)) ==
      ($past(word_now) & ~$past(clear_mask))
  ) else $error("clear removed a bit outside its mask");

endmodule

`default_nettype wire

// [sim/sps_host_model.sv]
// Host side of the serial command link: sends poll and clear commands.
// Assumes the bench supplies clk and calls the tasks one at a time.
`default_nettype none

module sps_host_model
  import sps_pkg::*;
(
  input  wire logic                  clk,
  output var  logic                  status_query_cmd,
  output var  logic                  status_clear_cmd,
  output var  logic [FLAG_WIDTH-1:0] clear_mask,
  input  wire logic                  reply_valid,
  input  wire logic                  reply_ack,
  input  wire logic [FLAG_WIDTH-1:0] reply_word
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    status_query_cmd = 1'h0;
    status_clear_cmd = 1'h0;
    clear_mask       = 16'h0000;
  end

  // ==========================================================================
  // Poll: one-cycle request, reply taken once valid shows
  task automatic poll(output logic [FLAG_WIDTH-1:0] word, output logic ack, output bit ok);
    int i;
    @(posedge clk);
    #1 status_query_cmd = 1'h1;
    @(posedge clk);
    #1 status_query_cmd = 1'h0;
    for (i = 0; i < 4; i++) begin
      if (reply_valid === 1'h1) break;
      @(posedge clk);
      #1;
    end
    ok   = (reply_valid === 1'h1);
    word = reply_word;
    ack  = reply_ack;
  endtask

  // ==========================================================================
  // Clear: mask is only meaningful with the strobe, so scramble it after
  task automatic clear(input logic [FLAG_WIDTH-1:0] mask);
    @(posedge clk);
    #1;
    clear_mask       = mask;
    status_clear_cmd = 1'h1;
    @(posedge clk);
    #1;
    status_clear_cmd = 1'h0;
    clear_mask       = ~mask;
  endtask
endmodule

`default_nettype wire

// [sim/test_sps_poll_status.sv]
// Self-checking bench for the poll status word.
// Assumes the host model drives commands; bench drives condition sources.
`default_nettype none

module test_sps_poll_status
  import sps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        reset;
  logic        query;
  logic        clr;
  logic [15:0] mask;
  logic        reply_valid;
  logic        reply_ack;
  logic [15:0] reply_word;
  logic [15:0] flags;
  logic [17:0] ev;
  logic        hold;
  logic        move;
  logic        chk;
  logic [5:0]  cnt;
  logic [1:0]  mode;
  int          n_errors;
  int          checks;

  // ==========================================================================
  // Instances; ev[16] and ev[17] are the second causes of bits 10 and 0
  sps_poll_status sps_poll_status_i (
    .clk(clk), .reset(reset), .status_query_cmd(query), .status_clear_cmd(clr),
    .clear_mask(mask), .imm_cmd_done(ev[15]), .nonvolatile_checksum_fault(ev[14]),
    .program_cmds_done(ev[13]), .cmd_exec_fault(ev[12]), .stop_condition_exit(ev[11]),
    .supply_undervolt(ev[10]), .supply_overvolt(ev[16]), .pos_err_over_hold(ev[9]),
    .holding_state(hold), .pos_err_over_move(ev[8]), .moving_state(move),
    .rx_fifo_overflow(ev[7]), .armed_condition_hit(ev[6]), .internal_check_active(chk),
    .rx_byte_stb(ev[5]), .rx_byte_count(cnt), .rx_framing_fault(ev[4]),
    .shutdown_condition_active(ev[3]), .soft_limit_reached(ev[2]),
    .rx_checksum_fault(ev[1]), .protocol_mode(mode), .rx_data_fault(ev[0]),
    .rx_packet_restart(ev[17]), .reply_valid(reply_valid), .reply_ack(reply_ack),
    .reply_word(reply_word), .poll_condition_flags(flags)
  );

  sps_host_model sps_host_model_i (
    .clk(clk), .status_query_cmd(query), .status_clear_cmd(clr), .clear_mask(mask),
    .reply_valid(reply_valid), .reply_ack(reply_ack), .reply_word(reply_word)
  );

  // ==========================================================================
  // Shared tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic poll_expect(input logic [15:0] exp);
    logic [15:0] w;
    logic        a;
    bit          ok;
    sps_host_model_i.poll(w, a, ok);
    if (!ok) begin
      n_errors++;
      summarize();
    end
    chk16("reply_word", exp, w);
    chk16("reply_ack", {15'h0000, exp == 16'h0000}, {15'h0000, a});
  endtask

  task automatic pulse(input int n);
    @(posedge clk);
    #1 ev = ev | (18'h00001 << n);
    @(posedge clk);
    #1 ev = ev & ~(18'h00001 << n);
  endtask

  // Qualifier levels come from the caller, never fixed at the instance
  task automatic set_quals(input logic h, input logic mv, input logic c, input logic [5:0] n);
    hold = h;
    move = mv;
    chk  = c;
    cnt  = n;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    chk16("flags", 16'h0000, flags);
    poll_expect(16'h0000);
    $display("test_reset done");
  endtask

  task automatic test_each_bit();
    int n;
    set_quals(1'h1, 1'h1, 1'h1, 6'h20);
    mode = 2'h2;
    for (n = 0; n < 16; n++) begin
      pulse(n);
      chk16("flags", 16'h0001 << n, flags);
      poll_expect(16'h0001 << n);
      sps_host_model_i.clear(16'hFFFF);
      chk16("flags", 16'h0000, flags);
    end
    $display("test_each_bit done");
  endtask

  task automatic test_qualifiers();
    int m;
    set_quals(1'h0, 1'h0, 1'h0, 6'h1F);
    pulse(9);
    pulse(8);
    pulse(6);
    pulse(5);
    chk16("flags", 16'h0000, flags);
    for (m = 0; m < 4; m++) begin
      mode = m[1:0];
      pulse(1);
      chk16("flags", {14'h0000, m[1], 1'h0}, flags);
      poll_expect({14'h0000, m[1], 1'h0});
      sps_host_model_i.clear(16'hFFFF);
    end
    pulse(16);
    pulse(17);
    chk16("flags", 16'h0401, flags);
    poll_expect(16'h0401);
    sps_host_model_i.clear(16'hFFFF);
    $display("test_qualifiers done");
  endtask

  task automatic test_double_buffer();
    pulse(15);
    pulse(12);
    sps_host_model_i.clear(16'hFFFF);
    chk16("flags", 16'h9000, flags);
    poll_expect(16'h9000);
    pulse(7);
    sps_host_model_i.clear(16'h8000);
    chk16("flags", 16'h1080, flags);
    sps_host_model_i.clear(16'hFFFF);
    chk16("flags", 16'h0080, flags);
    poll_expect(16'h0080);
    sps_host_model_i.clear(16'h0080);
    chk16("flags", 16'h0000, flags);
    $display("test_double_buffer done");
  endtask

  task automatic test_kill();
    @(posedge clk);
    #1 ev = ev | 18'h00008;
    @(posedge clk);
    #1;
    chk16("flags", 16'h0008, flags);
    poll_expect(16'h0008);
    sps_host_model_i.clear(16'hFFFF);
    repeat (3) @(posedge clk);
    #1;
    chk16("flags", 16'h0000, flags);
    ev = ev & ~18'h00008;
    $display("test_kill done");
  endtask

  task automatic test_set_wins();
    pulse(4);
    poll_expect(16'h0010);
    fork
      pulse(4);
      sps_host_model_i.clear(16'hFFFF);
    join
    chk16("flags", 16'h0010, flags);
    poll_expect(16'h0010);
    poll_expect(16'h0010);
    sps_host_model_i.clear(16'hFFFF);
    chk16("flags", 16'h0000, flags);
    $display("test_set_wins done");
  endtask

  // ==========================================================================
  // Clock and main sequence
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  initial begin
    reset    = 1'h1;
    ev       = 18'h00000;
    hold     = 1'h0;
    move     = 1'h0;
    chk      = 1'h0;
    cnt      = 6'h00;
    mode     = 2'h0;
    n_errors = 0;
    checks   = 0;
    repeat (16) @(posedge clk);
    #1 reset = 1'h0;
    test_reset();
    test_each_bit();
    test_qualifiers();
    test_double_buffer();
    test_kill();
    test_set_wins();
    summarize();
  end
endmodule

`default_nettype wire
